//--- hdl/dwell_timer.sv
// Counts control ticks while a condition holds and flags a long enough run.
// Assumes tick_in is a one-cycle pulse from the same clock domain.
`default_nettype none

module dwell_timer (
  input wire logic clk_in, // System clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic tick_in, // 1 ms tick pulse
  input wire logic cond_in, // Condition being timed
  input wire logic [15:0] limit_in, // Ticks needed to fire
  output logic fired_out // Condition held long enough
);
  import pos_loop_pkg::*;

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic fired_reg;

  // ==========================================================
  // Count saturates instead of wrapping
  assign count_next = !cond_in ? 16'h0000 :
                      (&count_reg) ? count_reg : count_reg + 16'h0001;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= 16'h0000;
      fired_reg <= 1'b0;
    end else begin
      if (tick_in || !cond_in) begin
        count_reg <= count_next;
      end
      fired_reg <= cond_in && (count_reg >= limit_in);
    end
  end

  assign fired_out = fired_reg;

  // ==========================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_run_clears;
    !cond_in |=> !fired_out && (count_reg == 16'h0000);
  endproperty
  a_run_clears: assert property (p_run_clears) else $error("dwell fired without condition");

endmodule : dwell_timer

`default_nettype wire

//--- hdl/pos_loop.sv
// Two-channel closed-loop position controller with APB register access.
// Assumes feedback and current readings arrive asynchronously as words,
// stable over many clocks, and that the power stage samples power each tick.
//
// The APB register port and the register addresses were chosen for this implementation.
`default_nettype none

module pos_loop #(
  parameter int TICK_CYCLES = pos_loop_pkg::TICK_CYCLES // Clocks per control tick
) (
  input wire logic clk_in, // 10 MHz system clock
  input wire logic rstn_in, // Async reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB write
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error on unmapped address
  input wire logic [15:0] nv_accel_in, // Stored default acceleration
  input wire logic [15:0] nv_decel_in, // Stored default deceleration
  input wire logic [15:0] nv_vel_in, // Stored default velocity
  input wire logic signed [15:0] fb_in [2], // Raw feedback per channel
  input wire logic [15:0] cur_in [2], // Measured motor current per channel
  output logic signed [15:0] power_out [2], // Applied power per channel
  output logic [1:0] limit_sw_out, // Simulated limit switch per channel
  output logic [1:0] estop_out, // Emergency stop latched per channel
  output logic [1:0] loop_err_out, // Loop error per channel
  output logic tick_out // 1 ms control tick
);
  import pos_loop_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ==========================================================
  // Register bus decode
  logic [31:0] ctrl_reg, gain_reg, ocur_reg, fbcfg_reg;
  logic [15:0] ilim_reg, accel_reg, decel_reg, vel_reg;
  logic signed [15:0] cmd_reg [2];
  logic [1:0] estop_reg;
  logic nv_load_reg;
  logic signed [15:0] speed_reg [2];
  logic signed [15:0] turns_reg [2];
  logic [1:0] oc_fire, le_fire;
  logic wr_en;
  logic hit;
  logic [31:0] rd_mux;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign hit = (paddr_in[1:0] == 2'b00) && (paddr_in <= OFS_TURNS);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit;
  assign prdata_out = (psel_in && hit) ? rd_mux : 32'h0000_0000;

  always_comb begin
    unique case (paddr_in)
      OFS_CTRL: rd_mux = ctrl_reg;
      OFS_GAIN: rd_mux = gain_reg;
      OFS_ILIM: rd_mux = {16'h0000, ilim_reg};
      OFS_RAMP: rd_mux = {decel_reg, accel_reg};
      OFS_VEL: rd_mux = {16'h0000, vel_reg};
      OFS_CMD0: rd_mux = {{16{cmd_reg[0][15]}}, cmd_reg[0]};
      OFS_CMD1: rd_mux = {{16{cmd_reg[1][15]}}, cmd_reg[1]};
      OFS_OCUR: rd_mux = ocur_reg;
      OFS_FBCFG: rd_mux = fbcfg_reg;
      OFS_STAT: rd_mux = {26'h0, limit_sw_out, estop_reg, le_fire};
      OFS_POWER: rd_mux = {power_out[1], power_out[0]};
      OFS_SPEED: rd_mux = {speed_reg[1], speed_reg[0]};
      OFS_TURNS: rd_mux = {turns_reg[1], turns_reg[0]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Stored defaults are taken on the first clock after reset release,
  // since an async reset may only load constants.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nv_load_reg <= 1'b1;
      ctrl_reg <= CTRL_RST;
      gain_reg <= GAIN_RST;
      ilim_reg <= ILIM_RST;
      ocur_reg <= OCUR_RST;
      fbcfg_reg <= FBCFG_RST;
      accel_reg <= 16'h0000;
      decel_reg <= 16'h0000;
      vel_reg <= 16'h0000;
      cmd_reg[0] <= 16'sh0000;
      cmd_reg[1] <= 16'sh0000;
    end else begin
      nv_load_reg <= 1'b0;
      if (nv_load_reg) begin
        accel_reg <= nv_accel_in;
        decel_reg <= nv_decel_in;
        vel_reg <= nv_vel_in;
      end
      if (wr_en && paddr_in == OFS_CTRL) ctrl_reg <= pwdata_in;
      if (wr_en && paddr_in == OFS_GAIN) gain_reg <= pwdata_in;
      if (wr_en && paddr_in == OFS_ILIM) ilim_reg <= pwdata_in[15:0];
      if (wr_en && paddr_in == OFS_OCUR) ocur_reg <= pwdata_in;
      if (wr_en && paddr_in == OFS_FBCFG) fbcfg_reg <= pwdata_in;
      if (wr_en && paddr_in == OFS_RAMP) begin
        accel_reg <= pwdata_in[15:0];
        decel_reg <= pwdata_in[31:16];
      end
      if (wr_en && paddr_in == OFS_VEL) vel_reg <= pwdata_in[15:0];
      if (wr_en && paddr_in == OFS_CMD0) cmd_reg[0] <= pwdata_in[15:0];
      if (wr_en && paddr_in == OFS_CMD1) cmd_reg[1] <= pwdata_in[15:0];
    end
  end

  // ==========================================================
  // Control tick
  logic [TW-1:0] tick_cnt_reg;
  logic tick;

  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
  assign tick_out = tick;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TW'(1);
  end

  // ==========================================================
  // Input synchronisers
  logic signed [15:0] fb_s1 [2], fb_s2 [2];
  logic [15:0] cur_s1 [2], cur_s2 [2];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 2; i++) begin
        fb_s1[i] <= 16'sh0000;
        fb_s2[i] <= 16'sh0000;
        cur_s1[i] <= 16'h0000;
        cur_s2[i] <= 16'h0000;
      end
    end else begin
      fb_s1 <= fb_in;
      fb_s2 <= fb_s1;
      cur_s1 <= cur_in;
      cur_s2 <= cur_s1;
    end
  end

  // ==========================================================
  // Shared settings
  logic [7:0] kp, ki, kd;
  logic [1:0] sens;
  logic act_limit;
  logic [15:0] le_thr, le_ms, oc_lim;
  logic [1:0] estop_clr;

  assign kp = gain_reg[7:0];
  assign ki = gain_reg[GAIN_KI +: 8];
  assign kd = gain_reg[GAIN_KD +: 8];
  assign sens = ctrl_reg[CTRL_SENS +: 2];
  assign act_limit = ctrl_reg[CTRL_ACT];
  assign le_thr = (sens == 2'd1) ? 16'(LE_THR_1) :
                  (sens == 2'd2) ? 16'(LE_THR_2) : 16'(LE_THR_3);
  assign le_ms = (sens == 2'd1) ? 16'(LE_MS_1) :
                 (sens == 2'd2) ? 16'(LE_MS_2) : 16'(LE_MS_3);
  // Fire only when strictly longer than the duration
  assign oc_lim = (&ocur_reg[OCUR_DUR +: 16]) ? 16'hffff :
                  ocur_reg[OCUR_DUR +: 16] + 16'h0001;
  assign estop_clr = (wr_en && paddr_in == OFS_STAT) ?
                     pwdata_in[STAT_ESTOP +: 2] : 2'b00;
  assign estop_out = estop_reg;
  assign loop_err_out = le_fire;
  assign limit_sw_out = oc_fire & {2{act_limit}};

  // New trip wins over a clear in the same cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) estop_reg <= 2'b00;
    else estop_reg <= (estop_reg & ~estop_clr) | (oc_fire & {2{!act_limit}});
  end

  // ==========================================================
  // Per-channel loop
  for (genvar g = 0; g < 2; g++) begin : g_ch
    mode_e mode;
    logic stop;
    logic signed [32:0] fb_mul, fb_shift;
    logic signed [15:0] fb_sc;
    logic signed [31:0] dest_fx, sp_reg, sp_next, rem;
    logic [31:0] arem, v_reg, v_up, v_acc, v_dn, v_new;
    logic [63:0] vv, dd;
    logic brake, arrive;
    logic signed [31:0] desired, err, prev_err_reg, abs_err, integ_reg, integ_sum, integ_next;
    logic signed [31:0] ilim, pid, pid_sat, cmd_sat, power_next;
    logic signed [15:0] power_reg, fb_prev_reg;
    logic signed [31:0] raw_delta, sc_delta;

    assign mode = mode_e'(ctrl_reg[2*g +: 2]);
    assign stop = estop_reg[g] || limit_sw_out[g] || le_fire[g];

    // Feedback scaling to the command range
    assign fb_mul = fb_s2[g] * $signed({1'b0, fbcfg_reg[15:0]});
    assign fb_shift = fb_mul >>> FRAC;
    assign fb_sc = (fb_shift > CMD_MAX) ? 16'(CMD_MAX) :
                   (fb_shift < -CMD_MAX) ? 16'(-CMD_MAX) : fb_shift[15:0];

    // Trajectory in fixed point, magnitude of speed toward the target
    assign dest_fx = {{8{cmd_reg[g][15]}}, cmd_reg[g], 8'h00};
    assign rem = dest_fx - sp_reg;
    assign arem = rem[31] ? 32'(-rem) : 32'(rem);
    assign vv = 64'(v_reg) * 64'(v_reg);
    assign dd = 64'({decel_reg, 1'b0}) * 64'(arem);
    assign brake = (vv >= dd);
    assign v_up = v_reg + 32'(accel_reg);
    assign v_acc = (v_up > 32'(vel_reg)) ? 32'(vel_reg) : v_up;
    assign v_dn = (v_reg > 32'(decel_reg)) ? v_reg - 32'(decel_reg) : 32'(decel_reg);
    assign v_new = (arem == 32'h0) ? 32'h0 : (brake ? v_dn : v_acc);
    assign arrive = (v_new >= arem);
    assign sp_next = arrive ? dest_fx :
                     (rem[31] ? sp_reg - $signed(v_new) : sp_reg + $signed(v_new));

    // Error and PID
    assign desired = (mode == MODE_REL) ? 32'(sp_reg >>> FRAC) : 32'(cmd_reg[g]);
    assign err = desired - 32'(fb_sc);
    assign abs_err = err[31] ? -err : err;
    assign ilim = 32'(ilim_reg);
    assign integ_sum = integ_reg + err;
    assign integ_next = (integ_sum > ilim) ? ilim :
                        (integ_sum < -ilim) ? -ilim : integ_sum;
    assign pid = err * $signed({24'h0, kp})
                 + integ_next * $signed({24'h0, ki})
                 + (err - prev_err_reg) * $signed({24'h0, kd});
    assign pid_sat = (pid > CMD_MAX) ? CMD_MAX : (pid < -CMD_MAX) ? -CMD_MAX : pid;
    assign cmd_sat = (32'(cmd_reg[g]) > CMD_MAX) ? CMD_MAX :
                     (32'(cmd_reg[g]) < -CMD_MAX) ? -CMD_MAX : 32'(cmd_reg[g]);
    assign power_next = stop ? 32'sh0 : (mode == MODE_OPEN) ? cmd_sat :
                        (mode == MODE_REL || mode == MODE_TRACK) ? pid_sat : 32'sh0;
    assign power_out[g] = power_reg;

    // Speed and turns
    assign raw_delta = 32'(fb_s2[g]) - 32'(fb_prev_reg);
    assign sc_delta = (32'(fb_sc) * $signed({24'h0, fbcfg_reg[FB_SPAN +: 8]})) >>> 11;

    always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
        sp_reg <= 32'sh0;
        v_reg <= 32'h0;
        prev_err_reg <= 32'sh0;
        integ_reg <= 32'sh0;
        power_reg <= 16'sh0000;
        fb_prev_reg <= 16'sh0000;
        speed_reg[g] <= 16'sh0000;
        turns_reg[g] <= 16'sh0000;
      end else if (tick) begin
        fb_prev_reg <= fb_s2[g];
        power_reg <= power_next[15:0];
        prev_err_reg <= err;
        if (mode == MODE_REL && !stop) begin
          sp_reg <= sp_next;
          v_reg <= arrive ? 32'h0 : v_new;
        end else begin
          // Start any later move from where the motor actually is
          sp_reg <= {{8{fb_sc[15]}}, fb_sc, 8'h00};
          v_reg <= 32'h0;
        end
        integ_reg <= (mode == MODE_OPEN || stop) ? 32'sh0 : integ_next;
        if (ctrl_reg[CTRL_ENC]) begin
          speed_reg[g] <= raw_delta[15:0];
          turns_reg[g] <= fb_s2[g] >>> fbcfg_reg[FB_CPR +: 4];
        end else begin
          speed_reg[g] <= 16'((raw_delta * $signed({24'h0, fbcfg_reg[FB_SPAN +: 8]})) >>> 11);
          turns_reg[g] <= sc_delta[15:0];
        end
      end
    end

    dwell_timer u_loop_err (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .tick_in(tick),
      .cond_in(sens != 2'd0 && mode != MODE_OPEN && abs_err > 32'(le_thr)),
      .limit_in(le_ms),
      .fired_out(le_fire[g])
    );

    dwell_timer u_over_cur (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .tick_in(tick),
      .cond_in(cur_s2[g] >= ocur_reg[15:0]),
      .limit_in(oc_lim),
      .fired_out(oc_fire[g])
    );

    // ========================================================
    // Channel checks
    property p_rel_end;
      @(posedge clk_in) disable iff (!rstn_in)
      tick && mode == MODE_REL && !stop && arrive |=> sp_reg == $past(dest_fx) && v_reg == 0;
    endproperty
    a_rel_end: assert property (p_rel_end) else $error("move did not end on target");

    property p_integ;
      @(posedge clk_in) disable iff (!rstn_in)
      integ_reg <= ilim && integ_reg >= -ilim;
    endproperty
    a_integ: assert property (p_integ) else $error("integrator beyond limit");

    property p_stop_zero;
      @(posedge clk_in) disable iff (!rstn_in)
      tick && stop |=> power_out[g] == 16'sh0000;
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("stopped channel drives power");

    property p_zero_err;
      @(posedge clk_in) disable iff (!rstn_in)
      tick && mode == MODE_TRACK && err == 0 && prev_err_reg == 0 && ki == 0 |=>
        power_out[g] == 16'sh0000;
    endproperty
    a_zero_err: assert property (p_zero_err) else $error("zero error gives power");

    property p_prop_only;
      @(posedge clk_in) disable iff (!rstn_in)
      tick && mode == MODE_TRACK && !stop && ki == 0 && kd == 0 && abs_err < 4 |=>
        power_out[g] == 16'($past(err) * $signed({24'h0, $past(kp)}));
    endproperty
    a_prop_only: assert property (p_prop_only) else $error("power not error times gain");

    property p_sat;
      @(posedge clk_in) disable iff (!rstn_in)
      power_out[g] <= 16'(CMD_MAX) && power_out[g] >= 16'(-CMD_MAX);
    endproperty
    a_sat: assert property (p_sat) else $error("power out of range");
  end

  // ==========================================================
  // Block checks
  property p_tick;
    @(posedge clk_in) disable iff (!rstn_in)
    tick |=> !tick [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("tick repeats too soon");

  property p_nv;
    @(posedge clk_in) disable iff (!rstn_in)
    nv_load_reg && !wr_en |=> accel_reg == $past(nv_accel_in) && vel_reg == $past(nv_vel_in);
  endproperty
  a_nv: assert property (p_nv) else $error("stored defaults not loaded");

  property p_estop_set;
    @(posedge clk_in) disable iff (!rstn_in)
    oc_fire[0] && !act_limit |=> estop_out[0] ##1 estop_out[0] || $past(estop_clr[0]);
  endproperty
  a_estop_set: assert property (p_estop_set) else $error("trip did not latch stop");

  property p_oc_release;
    @(posedge clk_in) disable iff (!rstn_in)
    cur_s2[0] < ocur_reg[15:0] |=> !oc_fire[0];
  endproperty
  a_oc_release: assert property (p_oc_release) else $error("trip without current");

endmodule : pos_loop

`default_nettype wire

//--- include/pos_loop_pkg.sv
// Constants shared by the closed-loop position block and its timer.
// Assumes a 10 MHz system clock and a 1 ms control tick derived from it.
`default_nettype none

package pos_loop_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GAIN = 8'h04;
  localparam logic [7:0] OFS_ILIM = 8'h08;
  localparam logic [7:0] OFS_RAMP = 8'h0c;
  localparam logic [7:0] OFS_VEL = 8'h10;
  localparam logic [7:0] OFS_CMD0 = 8'h14;
  localparam logic [7:0] OFS_CMD1 = 8'h18;
  localparam logic [7:0] OFS_OCUR = 8'h1c;
  localparam logic [7:0] OFS_FBCFG = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  localparam logic [7:0] OFS_POWER = 8'h28;
  localparam logic [7:0] OFS_SPEED = 8'h2c;
  localparam logic [7:0] OFS_TURNS = 8'h30;

  // ==========================================================
  // Field positions
  localparam int CTRL_SENS = 4;
  localparam int CTRL_ACT = 6;
  localparam int CTRL_ENC = 7;
  localparam int GAIN_KI = 8;
  localparam int GAIN_KD = 16;
  localparam int OCUR_DUR = 16;
  localparam int FB_CPR = 16;
  localparam int FB_SPAN = 24;
  localparam int STAT_ESTOP = 2;
  localparam int STAT_LIMIT = 4;
  localparam int FRAC = 8;

  // ==========================================================
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] GAIN_RST = 32'h0000_0001;
  localparam logic [15:0] ILIM_RST = 16'h0100;
  localparam logic [31:0] OCUR_RST = 32'h0064_ffff;
  localparam logic [31:0] FBCFG_RST = 32'h0a0a_0100;

  // ==========================================================
  // Ranges and loop-error sensitivity table (level 0 = off)
  localparam int CMD_MAX = 1000;
  localparam int LE_THR_1 = 100;
  localparam int LE_THR_2 = 250;
  localparam int LE_THR_3 = 500;
  localparam int LE_MS_1 = 250;
  localparam int LE_MS_2 = 500;
  localparam int LE_MS_3 = 1000;

  typedef enum logic [1:0] {MODE_OPEN, MODE_REL, MODE_TRACK} mode_e;

endpackage : pos_loop_pkg

`default_nettype wire

//--- tb/closed_loop_position_pid_tb_top.sv
// Self-checking bench for the two-channel position loop.
// Assumes a shortened tick and the partner model beside it.
`default_nettype none

module closed_loop_position_pid_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pos_loop_pkg::*;
  localparam int TCK = 20;
  localparam logic [39:0] RT [7] = '{{OFS_CTRL, CTRL_RST}, {OFS_GAIN, GAIN_RST},
    {OFS_ILIM, 16'h0, ILIM_RST}, {OFS_OCUR, OCUR_RST}, {OFS_FBCFG, FBCFG_RST},
    {OFS_RAMP, 32'h0200_0100}, {OFS_VEL, 32'h0000_0300}};
  logic clk_in, rstn_in, psel, penable, pwrite, move, pready, pslverr, tick, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [15:0] fb [2], fb_set [2], power [2];
  logic [15:0] cur [2], cur_set [2], lfsr;
  logic [1:0] limit_sw, estop, loop_err;
  int err_total, num_checks, kp, c, f, e;

  pos_loop #(.TICK_CYCLES(TCK)) DUT (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .nv_accel_in(16'h0100), .nv_decel_in(16'h0200), .nv_vel_in(16'h0300),
    .fb_in(fb), .cur_in(cur), .power_out(power), .limit_sw_out(limit_sw),
    .estop_out(estop), .loop_err_out(loop_err), .tick_out(tick));
  pos_loop_partner far_side (.clk_in(clk_in), .tick_in(tick), .move_in(move),
    .power_in(power), .fb_set_in(fb_set), .cur_set_in(cur_set), .fb_out(fb), .cur_out(cur));

  // ==========================================
  // Tasks
  function automatic int sat(int p);
    return p > CMD_MAX ? CMD_MAX : (p < -CMD_MAX ? -CMD_MAX : p);
  endfunction : sat
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin err_total++; print_verdict(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Ends three edges after a tick, so power and latched flags are settled
  task automatic ticks(input int k);
    int n;
    for (int i = 0; i < k; i++) begin
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (tick !== 1'b1 && n < 4 * TCK);
      if (n >= 4 * TCK) begin err_total++; print_verdict(); end
    end
    repeat (3) @(posedge clk_in);
  endtask : ticks

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ==========================================
  // Main sequence
  initial begin
    {rstn_in, psel, penable, pwrite, move, paddr, pwdata} = '0;
    fb_set = '{16'h0, 16'h0};
    cur_set = '{16'h0, 16'h0};
    err_total = 0;
    num_checks = 0;
    lfsr = 16'd3345;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (RT[i]) begin
      apb(0, RT[i][39:32], 32'h0);
      chk("reset_reg", RT[i][31:0], rd);
    end
    apb(1, OFS_VEL, 32'h0000_0123);
    apb(0, OFS_VEL, 32'h0);
    chk("vel", 32'h0000_0123, rd);
    apb(0, 8'h34, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1, 8'h06, 32'h5);
    chk("misaligned", 32'h1, {31'h0, er});
    $display("done registers");
    // Odd passes leave channel 1 open so modes stay apart
    for (int i = 0; i < 6; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      kp = int'(lfsr[2:0]) + 1;
      c = int'(lfsr) % 2001 - 1000;
      f = (i == 0) ? c : int'(lfsr[15:5]) - 1000;
      apb(1, OFS_CTRL, (i % 2) ? 32'h02 : 32'h0a);
      apb(1, OFS_GAIN, 32'(kp));
      apb(1, OFS_CMD0, 32'(c));
      apb(1, OFS_CMD1, 32'(c));
      fb_set <= '{16'(f), 16'(f)};
      ticks(3);
      // Feedback is clamped to the command range before the error is formed
      e = sat((c - sat(f)) * kp);
      chk("power0", 32'(e), 32'(power[0]));
      chk("power1", 32'((i % 2) ? sat(c) : e), 32'(power[1]));
    end
    $display("done tracking");
    apb(1, OFS_OCUR, {16'd3, 16'd500});
    for (int a = 0; a < 2; a++) begin
      apb(1, OFS_CTRL, 32'h0a | (a << CTRL_ACT));
      ticks(1);
      cur_set[1] <= 16'd600;
      ticks(3);
      cur_set[1] <= 16'd0;
      ticks(1);
      cur_set[1] <= 16'd600;
      ticks(3);
      chk("early", 32'h0, {30'h0, estop | limit_sw});
      ticks(1);
      chk("estop", a ? 32'h0 : 32'h2, {30'h0, estop});
      chk("limit", a ? 32'h2 : 32'h0, {30'h0, limit_sw});
      ticks(1);
      chk("stopped", 32'h0, 32'(power[1]));
      cur_set[1] <= 16'd0;
      ticks(1);
      apb(1, OFS_STAT, 32'h0000_0008);
      @(posedge clk_in);
      chk("clear", 32'h0, {30'h0, estop | limit_sw});
    end
    $display("done overcurrent");
    print_verdict();
  end
endmodule : closed_loop_position_pid_tb_top

`default_nettype wire

//--- tb/pos_loop_partner.sv
// Power stage and position sensor seen from the loop.
// Assumes power is sampled on the control tick.
`default_nettype none

module pos_loop_partner (
  input wire logic clk_in, // System clock
  input wire logic tick_in, // Control tick
  input wire logic move_in, // Load follows power
  input wire logic signed [15:0] power_in [2], // Applied power
  input wire logic signed [15:0] fb_set_in [2], // Rest position
  input wire logic [15:0] cur_set_in [2], // Imposed current
  output logic signed [15:0] fb_out [2], // Sensor reading
  output logic [15:0] cur_out [2] // Current reading
);
  logic signed [15:0] drift_reg [2];
  // ==========================================
  // Load drift, cleared when held still
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (!move_in) drift_reg[i] <= '0;
      else if (tick_in) drift_reg[i] <= drift_reg[i] + (power_in[i] >>> 6);
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      fb_out[i] = fb_set_in[i] + drift_reg[i];
      cur_out[i] = cur_set_in[i];
    end
  end
endmodule : pos_loop_partner

`default_nettype wire
